// ---- bench/isr_chk_sva.sv ----
// Concurrent checks on the router's register port and line outputs.
// Assumes one clock, aclk, with a synchronous active-low aresetn.
`timescale 1ns/100ps
module isr_chk #(
  parameter int unsigned LINES = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0] two_way_external_pin_oe,
  input wire logic [LINES-1:0] two_way_external_pin_term,
  input wire logic [LINES-1:0] chained_interrupt_o,
  input wire logic [LINES-1:0] chained_interrupt_oe,
  input wire logic [LINES-1:0] host_irq_req
);
  // ------------------------------------------------------------
  // One domain, so clock and reset are declared once.
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  resp_hold_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not closed after bready");
  rd_hold_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not closed after rready");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  busy_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while response pending");
  pin_reset_a: assert property (
    $rose(aresetn) |-> two_way_external_pin_oe == 12'h03F
    && two_way_external_pin_term == 12'h000)
    else $error("pin direction or termination wrong after reset");
  chain_reset_a: assert property (
    $rose(aresetn) |-> chained_interrupt_oe == '0 && host_irq_req == '0)
    else $error("chained line active after reset");
  chain_drive_a: assert property (
    (chained_interrupt_o & ~chained_interrupt_oe) == '0)
    else $error("chained line driven with no source");
endmodule // isr_chk

bind isr_top isr_chk #(.LINES(LINES)) u_isr_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .two_way_external_pin_oe, .two_way_external_pin_term,
  .chained_interrupt_o, .chained_interrupt_oe, .host_irq_req
);

// ---- bench/isr_far_model.sv ----
// Far side of the router: one more board on the chain, and the pins.
// Assumes the bench asks for a remote chained drive on remote_req.
`timescale 1ns/100ps
module isr_far_model #(
  parameter int HOLD = 100
) (
  input wire logic aclk,
  input wire logic [11:0] chained_interrupt_o,
  input wire logic [11:0] chained_interrupt_oe,
  input wire logic [11:0] two_way_external_pin_o,
  input wire logic [11:0] two_way_external_pin_oe,
  input wire logic [11:0] remote_req,
  output logic [11:0] chained_interrupt_i,
  output logic [11:0] two_way_external_pin_i
);
  logic [11:0] far_q = 12'h000;
  logic [11:0] float_q = 12'hA5A;
  logic [7:0] hold_q = 8'h00;

  // Each remote level is held a full microsecond before it may change.
  always @(posedge aclk) begin
    float_q <= ~float_q;
    if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end else if (remote_req != far_q) begin
      far_q <= remote_req;
      hold_q <= 8'(HOLD);
    end
  end

  // Chain wire is the OR of all drivers, seen by every board at once.
  assign chained_interrupt_i = (chained_interrupt_o & chained_interrupt_oe)
    | far_q;
  // An undriven pin floats, so it shows a changing pattern, not a level.
  assign two_way_external_pin_i = (two_way_external_pin_o
    & two_way_external_pin_oe) | (float_q & ~two_way_external_pin_oe);
endmodule // isr_far_model

// ---- bench/tb.sv ----
// Self-checking bench for the router over its AXI4-Lite port.
// Assumes the far-side model in isr_far_model and the bound checker.
`timescale 1ns/100ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] periodic_timer_source = 12'h000, remote_req = 12'h000;
  logic [4:0] misc = 5'h00;
  logic [11:0] two_way_external_pin_i, two_way_external_pin_o;
  logic [11:0] two_way_external_pin_oe, two_way_external_pin_term;
  logic [11:0] chained_interrupt_i, chained_interrupt_o;
  logic [11:0] chained_interrupt_oe, host_irq_req;
  logic [31:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [11:0] st = 12'h000;
  logic [11:0] v;
  int n_fail = 0;
  int checks = 0;
  int seed = 67;

  isr_top u_isr_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periodic_timer_source,
    .gps_pps_in(misc[0]), .irig_pps_in(misc[1]), .timecode_in(misc[2]),
    .ten_mhz_in(misc[3]), .master_time_in(misc[4]),
    .two_way_external_pin_i, .two_way_external_pin_o,
    .two_way_external_pin_oe, .two_way_external_pin_term,
    .chained_interrupt_i, .chained_interrupt_o, .chained_interrupt_oe,
    .host_irq_req);
  isr_far_model u_isr_far_model (.aclk, .chained_interrupt_o,
    .chained_interrupt_oe, .two_way_external_pin_o,
    .two_way_external_pin_oe, .remote_req, .chained_interrupt_i,
    .two_way_external_pin_i);

  // ------------------------------------------------------------
  // Clock, comparison and bus tasks.
  // ------------------------------------------------------------
  always #5 aclk = ~aclk;

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Ready rises with the request and holds until the answer is seen; a
  // spare edge at the end keeps back-to-back calls from double driving.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_b.push_back({30'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Each answer is matched against the oldest note left by the driver.
  always @(posedge aclk) begin : mon
    logic [33:0] e;
    if (s_axi_bvalid && s_axi_bready) begin
      check({30'h0, s_axi_bresp}, exp_b.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_r.pop_front();
      check(s_axi_rdata, e[31:0]);
      check({30'h0, s_axi_rresp}, {30'h0, e[33:32]});
    end
  end

  // The whole run needs a few hundred cycles; this stops a hang.
  initial begin
    idle(20000);
    n_fail++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Test sequence.
  // ------------------------------------------------------------
  initial begin
    idle(10);
    aresetn <= 1'b1;
    misc <= 5'($random(seed));
    periodic_timer_source <= 12'($random(seed));
    @(posedge aclk);
    check(32'(two_way_external_pin_oe), 32'h03F);
    check(32'(two_way_external_pin_term), 32'h0);
    check(32'(chained_interrupt_oe | host_irq_req), 32'h0);
    rd(isr_pkg::ADDR_STATE, 32'h0, 2'h0);
    rd(8'hFC, 32'h0, 2'h2);
    wr(8'hF0, 32'h1, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = 12'($random(seed));
      wr(isr_pkg::ADDR_SET, 32'(v), 2'h0);
      st = st | v;
      v = 12'($random(seed));
      wr(isr_pkg::ADDR_CLEAR, 32'(v), 2'h0);
      st = st & ~v;
      rd(isr_pkg::ADDR_STATE, 32'(st), 2'h0);
      check(32'(two_way_external_pin_o[5:0]), 32'(st[5:0]));
    end
    rd(isr_pkg::ADDR_SET, 32'h0, 2'h0);
    $display("test set clear done");
    for (int c = 0; c < 10; c++) begin
      wr(isr_pkg::ADDR_OUT_BASE + 8'h18, 32'h100 | 32'(c),
         c == 3 ? 2'h2 : 2'h0);
      check(32'(two_way_external_pin_oe[6]), 32'(c != 0));
    end
    rd(isr_pkg::ADDR_STATUS, 32'h1, 2'h0);
    wr(isr_pkg::ADDR_STATUS, 32'h1, 2'h0);
    rd(isr_pkg::ADDR_STATUS, 32'h0, 2'h0);
    wr(isr_pkg::ADDR_OUT_BASE, 32'h002, 2'h0);
    check(32'(two_way_external_pin_oe[0]), 32'h0);
    wr(isr_pkg::ADDR_OUT_BASE, 32'h302, 2'h0);
    check(32'(two_way_external_pin_oe[0]), 32'h1);
    check(32'(two_way_external_pin_term[0]), 32'h1);
    $display("test output routing done");
    for (int c = 0; c < 6; c++) begin
      wr(isr_pkg::ADDR_CHAIN_BASE + 8'h04, 32'(c), 2'h0);
      check(32'(chained_interrupt_oe[1]), 32'(c != 0));
    end
    wr(isr_pkg::ADDR_CLEAR, 32'hFFF, 2'h0);
    wr(isr_pkg::ADDR_CHAIN_BASE + 8'h08, 32'h002, 2'h0);
    wr(isr_pkg::ADDR_CHAIN_BASE + 8'h08, 32'h302, 2'h0);
    idle(4);
    check(32'(host_irq_req[2]), 32'h0);
    wr(isr_pkg::ADDR_SET, 32'h004, 2'h0);
    idle(6);
    check(32'(chained_interrupt_o[2]), 32'h1);
    check(32'(host_irq_req[2]), 32'h1);
    wr(isr_pkg::ADDR_PENDING, 32'h004, 2'h0);
    idle(4);
    check(32'(host_irq_req[2]), 32'h0);
    wr(isr_pkg::ADDR_CHAIN_BASE + 8'h08, 32'h322, 2'h0);
    idle(4);
    check(32'(host_irq_req[2]), 32'h1);
    wr(isr_pkg::ADDR_CHAIN_BASE + 8'h08, 32'h222, 2'h0);
    idle(2);
    check(32'(host_irq_req[2]), 32'h0);
    $display("test local chain done");
    wr(isr_pkg::ADDR_CHAIN_BASE + 8'h0C, 32'h310, 2'h0);
    remote_req <= 12'h008;
    idle(110);
    check(32'(host_irq_req[3] | chained_interrupt_oe[3]), 32'h0);
    remote_req <= 12'h000;
    idle(110);
    check(32'(host_irq_req[3]), 32'h1);
    wr(isr_pkg::ADDR_CHAIN_BASE + 8'h0C, 32'h330, 2'h0);
    wr(isr_pkg::ADDR_PENDING, 32'h008, 2'h0);
    idle(4);
    check(32'(host_irq_req[3]), 32'h1);
    $display("test remote chain done");
    stop_test();
  end
endmodule // tb

// ---- hdl/isr_top.sv ----
// Interrupt signal router: pulse generators, output line and chained
// line routing, chained trigger detection, AXI4-Lite register slave.
// Assumes timers come from logic on aclk; pins, chain and timing
// signals come from outside and are synchronised here.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps

module isr_top #(
  parameter int unsigned LINES = isr_pkg::NUM_LINES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0] periodic_timer_source,
  input wire logic gps_pps_in,
  input wire logic irig_pps_in,
  input wire logic timecode_in,
  input wire logic ten_mhz_in,
  input wire logic master_time_in,
  input wire logic [LINES-1:0] two_way_external_pin_i,
  output logic [LINES-1:0] two_way_external_pin_o,
  output logic [LINES-1:0] two_way_external_pin_oe,
  output logic [LINES-1:0] two_way_external_pin_term,
  input wire logic [LINES-1:0] chained_interrupt_i,
  output logic [LINES-1:0] chained_interrupt_o,
  output logic [LINES-1:0] chained_interrupt_oe,
  output logic [LINES-1:0] host_irq_req
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  logic [LINES-1:0] pin_meta_q;
  logic [LINES-1:0] pin_sync_q;
  logic [LINES-1:0] chain_meta_q;
  logic [LINES-1:0] chain_sync_q;
  logic [4:0] misc_meta_q;
  logic [4:0] misc_sync_q;

  // Outside signals pass two flops; only the second stage is read.
  always_ff @(posedge aclk) begin
    pin_meta_q <= two_way_external_pin_i;
    pin_sync_q <= pin_meta_q;
    chain_meta_q <= chained_interrupt_i;
    chain_sync_q <= chain_meta_q;
    misc_meta_q <= {master_time_in, ten_mhz_in, timecode_in,
                    irig_pps_in, gps_pps_in};
    misc_sync_q <= misc_meta_q;
  end

  wire logic gps_s = misc_sync_q[0];
  wire logic irig_s = misc_sync_q[1];
  wire logic timecode_s = misc_sync_q[2];
  wire logic ten_mhz_s = misc_sync_q[3];
  wire logic master_s = misc_sync_q[4];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------

  logic [LINES-1:0] state_q;
  logic [LINES-1:0] state_d;
  logic [LINES-1:0] pending_q;
  logic [LINES-1:0] pending_d;
  logic invalid_q;
  logic invalid_d;
  isr_pkg::isr_out_cfg_s out_cfg_q [LINES];
  isr_pkg::isr_ch_cfg_s ch_cfg_q [LINES];

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------

  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Address and data are taken independently; the write fires once both
  // are held, and no new beat is taken while the response is pending.
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire = aw_held_q && w_held_q && !bvalid_q;

  // Byte lanes: only the low two lanes carry register bits.
  wire logic [15:0] lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire logic [15:0] wr_bits = w_data_q[15:0] & lane_mask;
  wire logic [LINES-1:0] wr_mask = lane_mask[LINES-1:0];

  wire logic wr_state = wr_fire && aw_addr_q == isr_pkg::ADDR_STATE;
  wire logic wr_set = wr_fire && aw_addr_q == isr_pkg::ADDR_SET;
  wire logic wr_clear = wr_fire && aw_addr_q == isr_pkg::ADDR_CLEAR;
  wire logic wr_status = wr_fire && aw_addr_q == isr_pkg::ADDR_STATUS;
  wire logic wr_pend = wr_fire && aw_addr_q == isr_pkg::ADDR_PENDING;

  // Per-line config words sit at base + 4 * line.
  wire logic [5:0] wr_word = aw_addr_q[7:2];
  wire logic wr_out_area = aw_addr_q[7:6] == 2'h1 && aw_addr_q[1:0] == 2'h0;
  wire logic wr_ch_area = aw_addr_q[7:6] == 2'h2 && aw_addr_q[1:0] == 2'h0;
  wire logic [3:0] wr_line = wr_word[3:0];
  wire logic wr_line_ok = {2'h0, wr_line} < 6'(LINES);
  wire logic [3:0] wr_out_src = wr_bits[isr_pkg::OUT_SRC_LSB +: 4];

  // Routing a pin's own input back to that pin's output is refused.
  wire logic wr_loop = wr_out_src == 4'(isr_pkg::OUT_SRC_TRIGGER);
  wire logic wr_out = wr_fire && wr_out_area && wr_line_ok;
  wire logic wr_ch = wr_fire && wr_ch_area && wr_line_ok;
  wire logic wr_out_ok = wr_out && !wr_loop;
  wire logic wr_mapped = wr_state || wr_set || wr_clear || wr_status ||
                         wr_pend || wr_out || wr_ch;
  wire logic wr_error = !wr_mapped || (wr_out && wr_loop);

  // Handshake bookkeeping for the write channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      aw_held_q <= (aw_held_q || aw_take) && !wr_fire;
      w_held_q <= (w_held_q || w_take) && !wr_fire;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_error ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Payload capture; no reset needed, qualified by the held flags.
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_q <= s_axi_awaddr;
    end
    if (w_take) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // ----------------------------------------------------------------
  // Pulse generators and status
  // ----------------------------------------------------------------

  // Set and clear only touch bits written as one, so two processors can
  // drive different generators without a read-modify-write race.
  wire logic [LINES-1:0] set_mask = wr_set ? wr_bits[LINES-1:0] : '0;
  wire logic [LINES-1:0] clr_mask = wr_clear ? wr_bits[LINES-1:0] : '0;

  always_comb begin
    state_d = state_q;
    if (wr_state) begin
      state_d = (state_q & ~wr_mask) | (wr_bits[LINES-1:0] & wr_mask);
    end
    state_d = (state_d | set_mask) & ~clr_mask;
  end

  // Invalid flag is sticky; a new refusal wins over its own clear.
  assign invalid_d = (wr_out && wr_loop) ||
    (invalid_q && !(wr_status && wr_bits[isr_pkg::STAT_INVALID_BIT]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= isr_pkg::STATE_RESET;
      invalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      invalid_q <= invalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-line routing, configuration and trigger detection
  // ----------------------------------------------------------------

  logic [LINES-1:0] chain_level;
  logic [LINES-1:0] detect;
  logic [LINES-1:0] level_prev_q;
  logic [LINES-1:0] ch_drive_q;

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      localparam logic [3:0] GI = 4'(gi);
      localparam logic IS_OUT = gi < isr_pkg::NUM_OUT_LINES;

      // Configuration registers for this line.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          out_cfg_q[gi].src <= 4'(isr_pkg::OUT_SRC_PULSE);
          out_cfg_q[gi].dir_out <= IS_OUT;
          out_cfg_q[gi].term <= 1'b0;
          ch_cfg_q[gi] <= isr_pkg::CH_CFG_RESET;
        end else begin
          if (wr_out_ok && wr_line == GI) begin
            out_cfg_q[gi].src <= wr_out_src;
            out_cfg_q[gi].dir_out <= wr_bits[isr_pkg::OUT_DIR_BIT];
            out_cfg_q[gi].term <= wr_bits[isr_pkg::OUT_TERM_BIT];
          end
          if (wr_ch && wr_line == GI) begin
            ch_cfg_q[gi].src <= wr_bits[isr_pkg::CH_SRC_LSB +: 3];
            ch_cfg_q[gi].mode <= wr_bits[isr_pkg::CH_MODE_LSB +: 2];
            ch_cfg_q[gi].armed <= wr_bits[isr_pkg::CH_ARM_BIT];
            ch_cfg_q[gi].enabled <= wr_bits[isr_pkg::CH_EN_BIT];
          end
        end
      end

      // Chained line source select; unknown codes drive nothing.
      wire logic [2:0] csrc = ch_cfg_q[gi].src;
      wire logic ch_sel =
        (csrc == 3'(isr_pkg::CH_SRC_TIMER) & periodic_timer_source[gi]) |
        (csrc == 3'(isr_pkg::CH_SRC_PULSE) & state_q[gi]) |
        (csrc == 3'(isr_pkg::CH_SRC_TRIGGER) & pin_sync_q[gi]) |
        (csrc == 3'(isr_pkg::CH_SRC_GPS) & gps_s) |
        (csrc == 3'(isr_pkg::CH_SRC_IRIG) & irig_s);
      wire logic ch_src_valid = csrc != 3'(isr_pkg::CH_SRC_NONE) &&
                                csrc <= 3'(isr_pkg::CH_SRC_IRIG);

      // The chain is a shared wire; a board without a source stays off it.
      assign chained_interrupt_o[gi] = ch_drive_q[gi] && ch_src_valid;
      assign chained_interrupt_oe[gi] = ch_src_valid;

      // Seen level merges the chain with our own drive, so a lone board
      // still sees its own line and every board sees the same level.
      assign chain_level[gi] = chain_sync_q[gi] ||
        (ch_src_valid && ch_drive_q[gi]);

      // Trigger mode: edges against the previous level, or level itself.
      wire logic lvl = chain_level[gi];
      wire logic prv = level_prev_q[gi];
      wire logic [1:0] md = ch_cfg_q[gi].mode;
      assign detect[gi] =
        (md == 2'(isr_pkg::TRIG_RISING) & lvl & !prv) |
        (md == 2'(isr_pkg::TRIG_FALLING) & !lvl & prv) |
        (md == 2'(isr_pkg::TRIG_HIGH) & lvl) |
        (md == 2'(isr_pkg::TRIG_LOW) & !lvl);

      // Pending is latched only while armed; request needs enable too.
      assign pending_d[gi] = (detect[gi] && ch_cfg_q[gi].armed) ||
        (pending_q[gi] && !(wr_pend && wr_bits[gi]));
      assign host_irq_req[gi] = pending_q[gi] && ch_cfg_q[gi].armed &&
                                ch_cfg_q[gi].enabled;

      // Output line source select; trigger N is pin N itself.
      wire logic [3:0] osrc = out_cfg_q[gi].src;
      wire logic out_sel =
        (osrc == 4'(isr_pkg::OUT_SRC_TIMER) & periodic_timer_source[gi]) |
        (osrc == 4'(isr_pkg::OUT_SRC_PULSE) & state_q[gi]) |
        (osrc == 4'(isr_pkg::OUT_SRC_CHAINED) & chain_level[gi]) |
        (osrc == 4'(isr_pkg::OUT_SRC_GPS) & gps_s) |
        (osrc == 4'(isr_pkg::OUT_SRC_IRIG) & irig_s) |
        (osrc == 4'(isr_pkg::OUT_SRC_TIMECODE) & timecode_s) |
        (osrc == 4'(isr_pkg::OUT_SRC_TEN_MHZ) & ten_mhz_s) |
        (osrc == 4'(isr_pkg::OUT_SRC_MASTER) & master_s);
      wire logic out_src_valid = osrc != 4'(isr_pkg::OUT_SRC_NONE) &&
        osrc != 4'(isr_pkg::OUT_SRC_TRIGGER) &&
        osrc <= 4'(isr_pkg::OUT_SRC_MASTER);

      // Registered data bit; enable only with a source and output dir.
      logic pin_o_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_o_q <= 1'b0;
        end else begin
          pin_o_q <= out_sel;
        end
      end
      assign two_way_external_pin_o[gi] = pin_o_q;
      assign two_way_external_pin_oe[gi] = out_src_valid &&
        out_cfg_q[gi].dir_out;
      assign two_way_external_pin_term[gi] = out_cfg_q[gi].term;

      // Chained drive bit is registered too, keeping data outputs clean.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ch_drive_q[gi] <= 1'b0;
        end else begin
          ch_drive_q[gi] <= ch_sel;
        end
      end
    end
  endgenerate

  // Edge history and sticky pending bits; detection wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_prev_q <= '0;
      pending_q <= isr_pkg::PENDING_RESET;
    end else begin
      level_prev_q <= chain_level;
      pending_q <= pending_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------

  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [3:0] rd_line = s_axi_araddr[5:2];
  wire logic rd_aligned = s_axi_araddr[1:0] == 2'h0;
  wire logic rd_line_ok = {2'h0, rd_line} < 6'(LINES);
  wire logic rd_out = s_axi_araddr[7:6] == 2'h1 && rd_aligned && rd_line_ok;
  wire logic rd_ch = s_axi_araddr[7:6] == 2'h2 && rd_aligned && rd_line_ok;

  // Set and clear ports read as zero; they only act on writes.
  wire logic rd_state = s_axi_araddr == isr_pkg::ADDR_STATE;
  wire logic rd_wo = s_axi_araddr == isr_pkg::ADDR_SET ||
                     s_axi_araddr == isr_pkg::ADDR_CLEAR;
  wire logic rd_status = s_axi_araddr == isr_pkg::ADDR_STATUS;
  wire logic rd_pend = s_axi_araddr == isr_pkg::ADDR_PENDING;
  wire logic rd_hit = rd_state || rd_wo || rd_status || rd_pend ||
                      rd_out || rd_ch;

  wire isr_pkg::isr_out_cfg_s rd_ocfg = out_cfg_q[rd_line];
  wire isr_pkg::isr_ch_cfg_s rd_ccfg = ch_cfg_q[rd_line];
  wire logic [31:0] rd_out_word = {22'h0, rd_ocfg.term, rd_ocfg.dir_out,
                                   4'h0, rd_ocfg.src};
  wire logic [31:0] rd_ch_word = {22'h0, rd_ccfg.enabled, rd_ccfg.armed,
                                  2'h0, rd_ccfg.mode, 1'b0, rd_ccfg.src};
  wire logic [31:0] rd_word =
    rd_state ? {20'h0, state_q} :
    rd_status ? {31'h0, invalid_q} :
    rd_pend ? {20'h0, pending_q} :
    rd_out ? rd_out_word :
    rd_ch ? rd_ch_word : 32'h0;

  // One read in flight; data is captured at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // isr_top

// ---- pkg/isr_pkg.sv ----
// Shared constants and carriers for the interrupt signal router.
// Assumes a 32-bit AXI4-Lite register port and twelve lines per group.
package isr_pkg;

  localparam int unsigned NUM_LINES = 12;
  localparam int unsigned NUM_OUT_LINES = 6;

  // Register byte addresses.
  localparam logic [7:0] ADDR_STATE = 8'h00;
  localparam logic [7:0] ADDR_SET = 8'h10;
  localparam logic [7:0] ADDR_CLEAR = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_PENDING = 8'h34;
  localparam logic [7:0] ADDR_OUT_BASE = 8'h40;
  localparam logic [7:0] ADDR_CHAIN_BASE = 8'h80;

  // Field positions inside the per-line configuration words and the status word.
  localparam int unsigned OUT_SRC_LSB = 0;
  localparam int unsigned OUT_DIR_BIT = 8;
  localparam int unsigned OUT_TERM_BIT = 9;
  localparam int unsigned CH_SRC_LSB = 0;
  localparam int unsigned CH_MODE_LSB = 4;
  localparam int unsigned CH_ARM_BIT = 8;
  localparam int unsigned CH_EN_BIT = 9;
  localparam int unsigned STAT_INVALID_BIT = 0;

  // Reset values.
  localparam logic [11:0] STATE_RESET = 12'h000;
  localparam logic [11:0] PENDING_RESET = 12'h000;

  typedef enum logic [3:0] {
    OUT_SRC_NONE = 4'h0,
    OUT_SRC_TIMER = 4'h1,
    OUT_SRC_PULSE = 4'h2,
    OUT_SRC_TRIGGER = 4'h3,
    OUT_SRC_CHAINED = 4'h4,
    OUT_SRC_GPS = 4'h5,
    OUT_SRC_IRIG = 4'h6,
    OUT_SRC_TIMECODE = 4'h7,
    OUT_SRC_TEN_MHZ = 4'h8,
    OUT_SRC_MASTER = 4'h9
  } isr_out_src_e;

  typedef enum logic [2:0] {
    CH_SRC_NONE = 3'h0,
    CH_SRC_TIMER = 3'h1,
    CH_SRC_PULSE = 3'h2,
    CH_SRC_TRIGGER = 3'h3,
    CH_SRC_GPS = 3'h4,
    CH_SRC_IRIG = 3'h5
  } isr_ch_src_e;

  typedef enum logic [1:0] {
    TRIG_RISING = 2'h0,
    TRIG_FALLING = 2'h1,
    TRIG_HIGH = 2'h2,
    TRIG_LOW = 2'h3
  } isr_trig_e;

  typedef struct packed {
    logic term;
    logic dir_out;
    logic [3:0] src;
  } isr_out_cfg_s;

  typedef struct packed {
    logic enabled;
    logic armed;
    logic [1:0] mode;
    logic [2:0] src;
  } isr_ch_cfg_s;

  localparam isr_ch_cfg_s CH_CFG_RESET = 7'h00;

endpackage
